/* inc/width_mode_pkg.sv */
// shared constants and types for the mode and operand width controller
`default_nettype none
package width_mode_pkg;
  localparam int unsigned addr_width = 32;
  localparam logic reset_extended_mode = 1'b0;
  localparam logic reset_long_word = 1'b0;
  localparam logic [31:0] reset_pc = 32'h0000_0000;
  localparam logic [31:0] pc_increment = 32'h0000_0001;
  localparam logic [2:0] imm_bytes_plain = 3'h2;
  localparam logic [2:0] imm_bytes_one_extra = 3'h3;
  localparam logic [2:0] imm_bytes_two_extra = 3'h4;
  localparam logic [15:0] native_upper_zero = 16'h0000;
  localparam logic [7:0] top_byte_zero = 8'h00;

  typedef enum logic [1:0] {
    ctl_none = 2'h0,
    set_long_word_global = 2'h1,
    clear_long_word_global = 2'h2,
    enter_extended_address_mode = 2'h3
  } ctl_t;

  typedef enum logic [2:0] {
    register_mode = 3'h0,
    immediate_mode = 3'h1,
    indirect_mode = 3'h2,
    direct_address_mode = 3'h3,
    indexed_mode = 3'h4,
    pc_relative_mode = 3'h5,
    sp_relative_mode = 3'h6
  } addr_mode_t;

  typedef enum logic [1:0] {
    size_byte = 2'h0,
    size_word = 2'h1,
    size_long = 2'h2
  } op_size_t;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_armed = 3'b010,
    st_exec = 3'b100
  } seq_state_t;
endpackage
`default_nettype wire

/* rtl/mode_addr_adder.sv */
// address adder that wraps at 16 or 32 bits depending on the address mode
`timescale 1ns/100ps
`default_nettype none
module mode_addr_adder (
  input wire logic [31:0] base,
  input wire logic [31:0] offset,
  input wire logic extended,
  output logic [31:0] sum
);
  logic [15:0] low_sum;

  always_comb begin
    low_sum = base[15:0] + offset[15:0];
    // native wraps inside the low half so the upper half is never disturbed
    if (extended) begin
      sum = base + offset;
    end else begin
      sum = {base[31:16], low_sum};
    end
  end
endmodule
`default_nettype wire

/* rtl/operand_merge.sv */
// merges a new value into a destination at byte, word or long width
`timescale 1ns/100ps
`default_nettype none
module operand_merge (
  input wire logic [31:0] old_value,
  input wire logic [31:0] new_value,
  input wire width_mode_pkg::op_size_t size,
  output logic [31:0] merged
);
  import width_mode_pkg::*;

  always_comb begin
    case (size)
      size_byte: merged = {old_value[31:8], new_value[7:0]};
      // word keeps the upper half of old_value
      size_word: merged = {old_value[31:16], new_value[15:0]};
      size_long: merged = new_value;
      default: merged = old_value;
    endcase
  end
endmodule
`default_nettype wire

/* rtl/cpu_mode_and_operand_width_control.sv */
// core mode state, decoder directive latch and operand formation
`timescale 1ns/100ps
`default_nettype none
module cpu_mode_and_operand_width_control (
  input wire logic clock,
  input wire logic reset,
  input wire logic ctl_valid,
  input wire width_mode_pkg::ctl_t ctl_op,
  input wire logic dir_valid,
  input wire logic prefix_long_word_width,
  input wire logic prefix_word_width,
  input wire logic prefix_immediate_extend_one_byte,
  input wire logic prefix_immediate_extend_two_bytes,
  input wire logic op_valid,
  input wire width_mode_pkg::addr_mode_t op_mode,
  input wire logic op_word,
  input wire logic op_io,
  input wire logic op_jump,
  input wire logic [31:0] inst_field,
  input wire logic [31:0] src_value,
  input wire logic [31:0] dest_old,
  input wire logic [31:0] base_value,
  input wire logic load_valid,
  input wire logic [31:0] load_data,
  input wire logic pc_step,
  input wire logic instr_done,
  output logic extended_mode_q,
  output logic long_word_flag_q,
  output logic eff_long_q,
  output logic [2:0] imm_bytes_q,
  output logic busy_q,
  output logic [31:0] addr_q,
  output logic addr_valid_q,
  output logic addr_is_io_q,
  output logic [31:0] operand_q,
  output logic operand_valid_q,
  output logic [31:0] pc_q
);
  import width_mode_pkg::*;

  // mode group
  logic extended_mode_d;
  logic long_word_flag_d;
  // directive latch group
  seq_state_t state_q, state_d;
  logic pre_long_q, pre_long_d;
  logic pre_word_q, pre_word_d;
  logic pre_one_q, pre_one_d;
  logic pre_two_q, pre_two_d;
  logic eff_long_d;
  logic [2:0] imm_bytes_d;
  logic busy_d;
  // operand group
  op_size_t size_q, size_d;
  logic [31:0] addr_d;
  logic addr_valid_d;
  logic addr_is_io_d;
  logic [31:0] operand_d;
  logic operand_valid_d;
  logic [31:0] pc_d;
  // helpers
  logic eff_long;
  op_size_t op_size;
  logic [31:0] imm_value;
  logic [31:0] direct_addr;
  logic [31:0] disp_ext;
  logic [31:0] ea_base;
  logic [31:0] ea_sum;
  logic [31:0] pc_next;
  logic [31:0] merge_new;
  logic [31:0] merge_out;
  op_size_t merge_size;

  mode_addr_adder ea_adder (
    .base(ea_base),
    .offset(disp_ext),
    .extended(extended_mode_q),
    .sum(ea_sum)
  );

  mode_addr_adder pc_adder (
    .base(pc_q),
    .offset(pc_increment),
    .extended(extended_mode_q),
    .sum(pc_next)
  );

  operand_merge merger (
    .old_value(dest_old),
    .new_value(merge_new),
    .size(merge_size),
    .merged(merge_out)
  );

  // mode group: the two selections never touch each other
  always_comb begin
    extended_mode_d = extended_mode_q;
    long_word_flag_d = long_word_flag_q;
    if (ctl_valid) begin
      case (ctl_op)
        set_long_word_global: long_word_flag_d = 1'b1;
        clear_long_word_global: long_word_flag_d = 1'b0;
        enter_extended_address_mode: extended_mode_d = 1'b1;
        default: extended_mode_d = extended_mode_q;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      extended_mode_q <= reset_extended_mode;
      long_word_flag_q <= reset_long_word;
    end else begin
      extended_mode_q <= extended_mode_d;
      long_word_flag_q <= long_word_flag_d;
    end
  end

  // directive latch: several directives in a row combine for one instruction
  always_comb begin
    state_d = state_q;
    pre_long_d = pre_long_q;
    pre_word_d = pre_word_q;
    pre_one_d = pre_one_q;
    pre_two_d = pre_two_q;
    case (state_q)
      st_idle, st_armed: begin
        if (op_valid) begin
          state_d = st_exec;
        end else if (dir_valid) begin
          state_d = st_armed;
          pre_long_d = pre_long_q | prefix_long_word_width;
          pre_word_d = pre_word_q | prefix_word_width;
          pre_one_d = pre_one_q | prefix_immediate_extend_one_byte;
          pre_two_d = pre_two_q | prefix_immediate_extend_two_bytes;
        end
      end
      st_exec: begin
        if (instr_done) begin
          state_d = st_idle;
          pre_long_d = 1'b0;
          pre_word_d = 1'b0;
          pre_one_d = 1'b0;
          pre_two_d = 1'b0;
        end
      end
      default: begin
        state_d = st_idle;
        pre_long_d = 1'b0;
        pre_word_d = 1'b0;
        pre_one_d = 1'b0;
        pre_two_d = 1'b0;
      end
    endcase
    // prefix overrides the global flag without writing it
    eff_long = pre_long_q | (long_word_flag_q & ~pre_word_q);
    eff_long_d = eff_long;
    busy_d = (state_d != st_idle);
    if (pre_two_q) begin
      imm_bytes_d = imm_bytes_two_extra;
    end else if (pre_one_q) begin
      imm_bytes_d = imm_bytes_one_extra;
    end else begin
      imm_bytes_d = imm_bytes_plain;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= st_idle;
      pre_long_q <= 1'b0;
      pre_word_q <= 1'b0;
      pre_one_q <= 1'b0;
      pre_two_q <= 1'b0;
      eff_long_q <= reset_long_word;
      imm_bytes_q <= imm_bytes_plain;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pre_long_q <= pre_long_d;
      pre_word_q <= pre_word_d;
      pre_one_q <= pre_one_d;
      pre_two_q <= pre_two_d;
      eff_long_q <= eff_long_d;
      imm_bytes_q <= imm_bytes_d;
      busy_q <= busy_d;
    end
  end

  // operand formation
  always_comb begin
    if (!op_word) begin
      op_size = size_byte;
    end else if (eff_long) begin
      op_size = size_long;
    end else begin
      op_size = size_word;
    end
    // immediate straight from instruction bytes
    if (pre_two_q) begin
      imm_value = inst_field;
    end else if (pre_one_q) begin
      imm_value = {top_byte_zero, inst_field[23:0]};
    end else begin
      imm_value = {native_upper_zero, inst_field[15:0]};
    end
    if (pre_two_q) begin
      direct_addr = inst_field;
    end else if (pre_one_q) begin
      direct_addr = {top_byte_zero, inst_field[23:0]};
    end else begin
      direct_addr = {native_upper_zero, inst_field[15:0]};
    end
    if (pre_two_q) begin
      disp_ext = {{8{inst_field[23]}}, inst_field[23:0]};
    end else if (pre_one_q) begin
      disp_ext = {{16{inst_field[15]}}, inst_field[15:0]};
    end else begin
      disp_ext = {{24{inst_field[7]}}, inst_field[7:0]};
    end
    ea_base = (op_mode == pc_relative_mode) ? pc_q : base_value;
    merge_size = op_size;
    merge_new = src_value;
    if (op_valid && op_mode == immediate_mode) begin
      merge_new = imm_value;
    end else if (load_valid && !op_valid) begin
      merge_size = size_q;
      // load bytes arrive packed with the lowest address in bits 7..0
      merge_new = load_data;
    end
  end

  always_comb begin
    size_d = size_q;
    addr_d = addr_q;
    addr_valid_d = 1'b0;
    addr_is_io_d = addr_is_io_q;
    operand_d = operand_q;
    operand_valid_d = 1'b0;
    pc_d = pc_step ? pc_next : pc_q;
    if (op_valid) begin
      size_d = op_size;
      case (op_mode)
        register_mode, immediate_mode: begin
          operand_d = merge_out;
          operand_valid_d = 1'b1;
        end
        direct_address_mode: begin
          if (op_jump) begin
            pc_d = direct_addr;
          end else begin
            addr_d = direct_addr;
            addr_valid_d = 1'b1;
            addr_is_io_d = op_io;
          end
        end
        indirect_mode: begin
          addr_d = base_value;
          addr_valid_d = 1'b1;
          addr_is_io_d = op_io;
        end
        indexed_mode, sp_relative_mode: begin
          addr_d = ea_sum;
          addr_valid_d = 1'b1;
          addr_is_io_d = 1'b0;
        end
        pc_relative_mode: begin
          if (op_jump) begin
            pc_d = ea_sum;
          end else begin
            addr_d = ea_sum;
            addr_valid_d = 1'b1;
            addr_is_io_d = 1'b0;
          end
        end
        default: addr_valid_d = 1'b0;
      endcase
    end else if (load_valid && state_q == st_exec) begin
      operand_d = merge_out;
      operand_valid_d = 1'b1;
    end
    // carries past bit 15 are dropped while native
    if (!extended_mode_q) begin
      pc_d[31:16] = native_upper_zero;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      size_q <= size_byte;
      addr_q <= reset_pc;
      addr_valid_q <= 1'b0;
      addr_is_io_q <= 1'b0;
      operand_q <= reset_pc;
      operand_valid_q <= 1'b0;
      pc_q <= reset_pc;
    end else begin
      size_q <= size_d;
      addr_q <= addr_d;
      addr_valid_q <= addr_valid_d;
      addr_is_io_q <= addr_is_io_d;
      operand_q <= operand_d;
      operand_valid_q <= operand_valid_d;
      pc_q <= pc_d;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // the instruction may follow its directive at once or after one idle cycle
  sequence s_long_prefix_then_op;
    dir_valid && prefix_long_word_width && !op_valid && state_q != st_exec
    ##[1:2] op_valid && state_q == st_armed;
  endsequence

  sequence s_word_load;
    load_valid && !op_valid && state_q == st_exec && size_q == size_word;
  endsequence

  // own disable: the default one would mask every attempt started in reset
  reset_modes_a: assert property (
    @(posedge clock) disable iff (1'b0)
    reset |=> !extended_mode_q && !long_word_flag_q && pc_q == reset_pc)
    else $error("modes not cleared by reset");
  ext_sticky_a: assert property (
    extended_mode_q |=> extended_mode_q)
    else $error("extended mode left without reset");
  ext_enter_a: assert property (
    ctl_valid && ctl_op == enter_extended_address_mode |=> extended_mode_q && $stable(long_word_flag_q))
    else $error("extended mode not entered");
  lw_persist_a: assert property (
    !(ctl_valid && (ctl_op == set_long_word_global || ctl_op == clear_long_word_global))
    |=> $stable(long_word_flag_q))
    else $error("long word flag changed without control op");
  prefix_scope_a: assert property (
    s_long_prefix_then_op |-> eff_long ##1 $stable(long_word_flag_q))
    else $error("long prefix not applied or leaked into global state");
  prefix_clear_a: assert property (
    state_q == st_exec && instr_done |=> state_q == st_idle ##1 eff_long_q == long_word_flag_q)
    else $error("prefix overrides survived the instruction");
  word_load_a: assert property (
    s_word_load |=> operand_valid_q && operand_q[31:16] == $past(dest_old[31:16])
      && operand_q[15:0] == $past(load_data[15:0]))
    else $error("word load disturbed upper half");
  imm_zero_ext_a: assert property (
    op_valid && op_mode == immediate_mode && op_size == size_long && !pre_one_q && !pre_two_q
    |=> operand_q[31:16] == native_upper_zero)
    else $error("16-bit immediate not zero extended");
  imm_24bit_a: assert property (
    op_valid && op_mode == immediate_mode && op_size == size_long && pre_one_q && !pre_two_q
    |=> operand_q == {top_byte_zero, $past(inst_field[23:0])})
    else $error("24-bit immediate wrong");
  direct_space_a: assert property (
    op_valid && op_mode == direct_address_mode && !op_jump
    |=> addr_valid_q && addr_is_io_q == $past(op_io))
    else $error("direct address space wrong");
  native_pc_a: assert property (
    !extended_mode_q && !$past(extended_mode_q) |-> pc_q[31:16] == native_upper_zero)
    else $error("pc upper word nonzero in native mode");
  native_wrap_a: assert property (
    op_valid && op_mode == indexed_mode && !extended_mode_q
    |=> addr_q[31:16] == $past(base_value[31:16]))
    else $error("native address arithmetic touched upper half");
endmodule
`default_nettype wire

/* test/cpu_mode_and_operand_width_control_test.sv */
// self-checking bench for the mode and operand width controller
`timescale 1ns/100ps
`default_nettype none
module cpu_mode_and_operand_width_control_test;
  import width_mode_pkg::*;
  logic clock, reset, ctl_valid, dir_valid, pf_long, pf_word, pf_ext1, pf_ext2;
  logic op_valid, op_word, op_io, op_jump, load_valid, pc_step, instr_done;
  ctl_t ctl_op;
  addr_mode_t op_mode;
  logic [31:0] inst_field, src_value, dest_old, base_value, load_data;
  logic extended_mode_q, long_word_flag_q, eff_long_q, busy_q, addr_valid_q;
  logic addr_is_io_q, operand_valid_q;
  logic [2:0] imm_bytes_q;
  logic [31:0] addr_q, operand_q, pc_q, exp_v;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  cpu_mode_and_operand_width_control dut (
    .clock(clock), .reset(reset), .ctl_valid(ctl_valid), .ctl_op(ctl_op),
    .dir_valid(dir_valid), .prefix_long_word_width(pf_long), .prefix_word_width(pf_word),
    .prefix_immediate_extend_one_byte(pf_ext1), .prefix_immediate_extend_two_bytes(pf_ext2),
    .op_valid(op_valid), .op_mode(op_mode), .op_word(op_word), .op_io(op_io),
    .op_jump(op_jump), .inst_field(inst_field), .src_value(src_value),
    .dest_old(dest_old), .base_value(base_value), .load_valid(load_valid),
    .load_data(load_data), .pc_step(pc_step), .instr_done(instr_done),
    .extended_mode_q(extended_mode_q), .long_word_flag_q(long_word_flag_q),
    .eff_long_q(eff_long_q), .imm_bytes_q(imm_bytes_q), .busy_q(busy_q),
    .addr_q(addr_q), .addr_valid_q(addr_valid_q), .addr_is_io_q(addr_is_io_q),
    .operand_q(operand_q), .operand_valid_q(operand_valid_q), .pc_q(pc_q)
  );
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // generous ceiling; the sequence needs under 150 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      $display("BAD %0t timeout", $time);
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // strobes were raised at the previous edge; drop them after this one samples
  task automatic fire;
    @(posedge clock);
    ctl_valid <= 1'b0;
    dir_valid <= 1'b0;
    op_valid <= 1'b0;
    load_valid <= 1'b0;
    pc_step <= 1'b0;
    instr_done <= 1'b0;
    #1;
  endtask
  task automatic ctl(input ctl_t c);
    @(posedge clock);
    ctl_valid <= 1'b1;
    ctl_op <= c;
    fire();
  endtask
  task automatic dir(input logic l, input logic w, input logic e1, input logic e2);
    @(posedge clock);
    dir_valid <= 1'b1;
    pf_long <= l;
    pf_word <= w;
    pf_ext1 <= e1;
    pf_ext2 <= e2;
    fire();
  endtask
  task automatic op(input addr_mode_t m, input logic wd, input logic io, input logic jp,
                    input logic [31:0] f, input logic [31:0] s, input logic [31:0] b);
    @(posedge clock);
    op_valid <= 1'b1;
    op_mode <= m;
    op_word <= wd;
    op_io <= io;
    op_jump <= jp;
    inst_field <= f;
    src_value <= s;
    base_value <= b;
    fire();
  endtask
  task automatic load(input logic [31:0] data);
    @(posedge clock);
    load_valid <= 1'b1;
    load_data <= data;
    fire();
  endtask
  task automatic done;
    @(posedge clock);
    instr_done <= 1'b1;
    fire();
  endtask
  task automatic step;
    @(posedge clock);
    pc_step <= 1'b1;
    fire();
  endtask
  task automatic reg_op(input logic wd, input logic [31:0] exp);
    op(register_mode, wd, 1'b0, 1'b0, 32'h0, 32'h9abcdef0, 32'h0);
    chk(operand_valid_q, 1'b1);
    chk(operand_q, exp);
    done();
  endtask
  initial begin
    reset = 1'b1;
    {ctl_valid, dir_valid, pf_long, pf_word, pf_ext1, pf_ext2} = '0;
    {op_valid, op_word, op_io, op_jump, load_valid, pc_step, instr_done} = '0;
    ctl_op = ctl_none;
    op_mode = register_mode;
    inst_field = '0;
    src_value = '0;
    base_value = '0;
    load_data = '0;
    dest_old = 32'h12345678;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    #1;
    chk(extended_mode_q, 1'b0);
    chk(long_word_flag_q, 1'b0);
    chk(imm_bytes_q, imm_bytes_plain);
    chk(busy_q, 1'b0);
    chk(pc_q, 32'h0);
    reg_op(1'b1, 32'h1234def0);
    dir(1'b1, 1'b0, 1'b0, 1'b0);
    chk(busy_q, 1'b1);
    reg_op(1'b1, 32'h9abcdef0);
    @(posedge clock);
    #1;
    chk(busy_q, 1'b0);
    chk(eff_long_q, 1'b0);
    chk(long_word_flag_q, 1'b0);
    reg_op(1'b1, 32'h1234def0);
    reg_op(1'b0, 32'h123456f0);
    ctl(set_long_word_global);
    chk(long_word_flag_q, 1'b1);
    chk(extended_mode_q, 1'b0);
    reg_op(1'b1, 32'h9abcdef0);
    dir(1'b0, 1'b1, 1'b0, 1'b0);
    reg_op(1'b1, 32'h1234def0);
    reg_op(1'b1, 32'h9abcdef0);
    ctl(ctl_none);
    chk(long_word_flag_q, 1'b1);
    ctl(clear_long_word_global);
    chk(long_word_flag_q, 1'b0);
    dest_old = 32'hffffffff;
    for (int i = 0; i < 3; i++) begin
      dir(1'b1, 1'b0, i == 1, i == 2);
      op(immediate_mode, 1'b1, 1'b0, 1'b0, 32'h12345678, 32'h0, 32'h0);
      exp_v = (i == 2) ? 32'h12345678 : (i == 1) ? 32'h00345678 : 32'h00005678;
      chk(operand_q, exp_v);
      chk(addr_valid_q, 1'b0);
      chk(eff_long_q, 1'b1);
      chk(imm_bytes_q, (i == 2) ? imm_bytes_two_extra :
          (i == 1) ? imm_bytes_one_extra : imm_bytes_plain);
      done();
    end
    dest_old = 32'h12345678;
    for (int i = 0; i < 3; i++) begin
      dir(i == 2, 1'b0, i == 1, i == 2);
      op(direct_address_mode, 1'b1, i == 0, 1'b0, 32'h12345e22, 32'h0, 32'h0);
      exp_v = (i == 2) ? 32'h12345e22 : (i == 1) ? 32'h00345e22 : 32'h00005e22;
      chk(addr_valid_q, 1'b1);
      chk(addr_q, exp_v);
      chk(addr_is_io_q, i == 0);
      load(32'h07050301);
      chk(operand_valid_q, 1'b1);
      chk(operand_q, (i == 2) ? 32'h07050301 : 32'h12340301);
      done();
    end
    op(direct_address_mode, 1'b1, 1'b0, 1'b1, 32'habcdffff, 32'h0, 32'h0);
    chk(pc_q, 32'h0000ffff);
    done();
    step();
    chk(pc_q, 32'h00000000);
    // native relative jump borrows inside the low word only
    op(pc_relative_mode, 1'b1, 1'b0, 1'b1, 32'h000000fe, 32'h0, 32'h0);
    chk(pc_q, 32'h0000fffe);
    done();
    op(indexed_mode, 1'b1, 1'b0, 1'b0, 32'h000000ff, 32'h0, 32'h00010000);
    chk(addr_q, 32'h0001ffff);
    done();
    op(sp_relative_mode, 1'b1, 1'b0, 1'b0, 32'h000000fc, 32'h0, 32'h07ff7f00);
    chk(addr_q, 32'h07ff7efc);
    done();
    ctl(enter_extended_address_mode);
    chk(extended_mode_q, 1'b1);
    ctl(clear_long_word_global);
    chk(extended_mode_q, 1'b1);
    op(direct_address_mode, 1'b1, 1'b0, 1'b1, 32'h0000ffff, 32'h0, 32'h0);
    done();
    step();
    chk(pc_q, 32'h00010000);
    op(pc_relative_mode, 1'b1, 1'b0, 1'b1, 32'h000000fe, 32'h0, 32'h0);
    chk(pc_q, 32'h0000fffe);
    done();
    op(pc_relative_mode, 1'b1, 1'b0, 1'b0, 32'h00000010, 32'h0, 32'h0);
    chk(addr_q, 32'h0001000e);
    chk(addr_is_io_q, 1'b0);
    done();
    op(indexed_mode, 1'b1, 1'b0, 1'b0, 32'h000000ff, 32'h0, 32'h00010000);
    chk(addr_q, 32'h0000ffff);
    done();
    op(indirect_mode, 1'b1, 1'b1, 1'b0, 32'h0, 32'h0, 32'h12345678);
    chk(addr_q, 32'h12345678);
    chk(addr_is_io_q, 1'b1);
    done();
    // a second reset is the only way back to compatible mode
    @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    #1;
    chk(extended_mode_q, 1'b0);
    chk(pc_q, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
